// >>> hdl/tone_pkg.sv
// Purpose: constants, types and helpers shared by the tone pair decoder
// Assumes: 25 MHz pclk, limited tone inputs already squared up outside
// Notes:   register offsets are byte addresses on a 32-bit bus
package tone_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 40;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PGUARD  = 8'h04;
    localparam logic [7:0] OFS_AGUARD  = 8'h08;
    localparam logic [7:0] OFS_RXDATA  = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_EVT     = 8'h14;
    localparam logic [7:0] OFS_EVT_CLR = 8'h18;
    localparam logic [7:0] OFS_EVT_EN  = 8'h1c;

    localparam int CTRL_IRQ_BIT = 0;
    localparam int CTRL_CP_BIT  = 1;
    localparam int ST_VALID_BIT = 0;
    localparam int ST_DSTEER_BIT = 1;
    localparam int ST_EARLY_BIT = 2;
    localparam int EV_REG_BIT   = 0;
    localparam int EV_PAUSE_BIT = 1;
    localparam int EV_W         = 2;

    localparam int PRESENT_GUARD_MS = 40;
    localparam int ABSENT_GUARD_MS  = 40;
    localparam int PRESENT_GUARD_DEF = PRESENT_GUARD_MS * (CLK_HZ / 1000);
    localparam int ABSENT_GUARD_DEF  = ABSENT_GUARD_MS * (CLK_HZ / 1000);
    localparam int SETTLE_NS  = 200;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GUARD_W    = 24;

    localparam int TOL_PCT    = 3;
    localparam int MATCH_RUNS = 2;
    localparam int MEAS_W     = 17;
    localparam int LOW_F0  = 697;
    localparam int LOW_F1  = 770;
    localparam int LOW_F2  = 852;
    localparam int LOW_F3  = 941;
    localparam int HIGH_F0 = 1209;
    localparam int HIGH_F1 = 1336;
    localparam int HIGH_F2 = 1477;
    localparam int HIGH_F3 = 1633;

    localparam logic [3:0] CODE_ZERO = 4'ha;
    localparam logic [3:0] CODE_STAR = 4'hb;
    localparam logic [3:0] CODE_HASH = 4'hc;
    localparam logic [3:0] CODE_A    = 4'hd;
    localparam logic [3:0] CODE_D    = 4'h0;
    localparam logic [1:0] LAST_IDX  = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_QUAL   = 2'b01,
        ST_SETTLE = 2'b10,
        ST_HELD   = 2'b11
    } steer_e;

    function automatic logic [3:0] code_of(input logic [1:0] row, input logic [1:0] col);
        logic [3:0] r4;
        r4 = {2'h0, row};
        if (col == LAST_IDX)
            code_of = (row == LAST_IDX) ? CODE_D : CODE_A + r4;
        else if (row != LAST_IDX)
            code_of = 4'((r4 * 4'h3) + {2'h0, col} + 4'h1);
        else if (col == 2'h0)
            code_of = CODE_STAR;
        else
            code_of = (col == 2'h1) ? CODE_ZERO : CODE_HASH;
    endfunction : code_of
endpackage : tone_pkg

// >>> hdl/tone_meas_if.sv
// Purpose: carries one tone group's measurement to the steering logic
// Assumes: single pclk domain
// Notes:   idx is meaningful only while valid is high
`timescale 1ns/1ns
interface tone_meas_if;
    logic [1:0] idx;
    logic       valid;
    modport src (output idx, output valid);
    modport dst (input idx, input valid);
endinterface : tone_meas_if

// >>> hdl/tone_meter.sv
// Purpose: period counter that matches one limited tone to four frequencies
// Assumes: tone input already synchronised to pclk
// Notes:   a match needs two periods in a row, which rejects voice bursts
`timescale 1ns/1ns
module tone_meter #(
    parameter int F0 = tone_pkg::LOW_F0,
    parameter int F1 = tone_pkg::LOW_F1,
    parameter int F2 = tone_pkg::LOW_F2,
    parameter int F3 = tone_pkg::LOW_F3
)(
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // limited tone
    input  wire logic  tone,
    // measurement
    tone_meas_if.src   meas
);
    import tone_pkg::*;

    localparam int MAX_CNT = (CLK_HZ / F0) * (100 + TOL_PCT) / 100;

    function automatic logic near(input logic [MEAS_W-1:0] c, input int f);
        int p;
        p = CLK_HZ / f;
        near = (int'(c) >= p * (100 - TOL_PCT) / 100) && (int'(c) <= p * (100 + TOL_PCT) / 100);
    endfunction : near

    logic              tone_d;
    logic [MEAS_W-1:0] cnt;
    logic [1:0]        runs;
    logic [1:0]        last_idx;

    wire       rise = tone & ~tone_d;
    wire       over = int'(cnt) > MAX_CNT;
    wire [3:0] hit  = {near(cnt, F3), near(cnt, F2), near(cnt, F1), near(cnt, F0)};
    wire       any  = |hit;
    wire [1:0] enc  = hit[3] ? 2'h3 : hit[2] ? 2'h2 : hit[1] ? 2'h1 : 2'h0;
    wire       same = any && (enc == last_idx) && (runs != 2'h0);
    wire [1:0] next_runs = !any ? 2'h0 : !same ? 2'h1 : (runs == 2'h3) ? runs : runs + 2'h1;

    // period counter, one count per pclk between rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_d     <= 1'b0;
            cnt        <= '0;
            runs       <= 2'h0;
            last_idx   <= 2'h0;
            meas.idx   <= 2'h0;
            meas.valid <= 1'b0;
        end else begin
            tone_d <= tone;
            if (rise) begin
                cnt        <= '0;
                runs       <= next_runs;
                last_idx   <= enc;
                meas.idx   <= enc;
                meas.valid <= int'(next_runs) >= MATCH_RUNS;
            end else if (over) begin
                runs       <= 2'h0;
                meas.valid <= 1'b0;
            end else begin
                cnt <= cnt + MEAS_W'(1);
            end
        end
    end

    // a stalled tone must drop the match within one overlong period
    chk_meter_stall: assert property (@(posedge pclk) disable iff (!presetn)
        (over && !rise) |=> !meas.valid)
        else $error("tone match held after period overflow");
endmodule : tone_meter

// >>> hdl/tone_pair_decode_steering.sv
// Purpose: tone pair decode, steering guard timing and APB register file
// Assumes: limited low, high and call progress tones arrive asynchronously
// Notes:   steering node is a counter, so guard times are set in pclk cycles
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module tone_pair_decode_steering #(
    parameter int PRESENT_GUARD_CYC = tone_pkg::PRESENT_GUARD_DEF,
    parameter int ABSENT_GUARD_CYC  = tone_pkg::ABSENT_GUARD_DEF
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // limited line tones
    input  wire logic        low_tone,
    input  wire logic        high_tone,
    input  wire logic        cp_tone,
    // steering and pins
    output logic             early_steer,
    output logic             guard_drive,
    output logic             irq_or_tone_out_o,
    output logic             irq_or_tone_out_oe,
    // interrupt
    output logic             irq
);
    import tone_pkg::*;

    // two-flop synchronisers; only the second stage is read
    logic [2:0] sync_a;
    logic [2:0] sync_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {cp_tone, high_tone, low_tone};
            sync_b <= sync_a;
        end
    end

    tone_meas_if low_m ();
    tone_meas_if high_m ();

    tone_meter #(.F0(LOW_F0), .F1(LOW_F1), .F2(LOW_F2), .F3(LOW_F3)) u_low (
        .pclk    (pclk),
        .presetn (presetn),
        .tone    (sync_b[0]),
        .meas    (low_m)
    );

    tone_meter #(.F0(HIGH_F0), .F1(HIGH_F1), .F2(HIGH_F2), .F3(HIGH_F3)) u_high (
        .pclk    (pclk),
        .presetn (presetn),
        .tone    (sync_b[1]),
        .meas    (high_m)
    );

    // registers
    logic               irq_mode;
    logic               cp_mode;
    logic [GUARD_W-1:0] pguard;
    logic [GUARD_W-1:0] aguard;
    logic [3:0]         rx_code;
    logic [3:0]         pend_code;
    logic               rx_valid;
    logic               irq_pend;
    logic               dsteer;
    logic [EV_W-1:0]    evt;
    logic [EV_W-1:0]    evt_en;
    steer_e             state;
    steer_e             next_state;
    logic [GUARD_W-1:0] scnt;

    // apb decode
    wire acc_first = psel & penable & ~pready;
    wire acc_done  = psel & penable & pready;
    wire hit_ctrl  = paddr == OFS_CTRL;
    wire hit_pg    = paddr == OFS_PGUARD;
    wire hit_ag    = paddr == OFS_AGUARD;
    wire hit_rx    = paddr == OFS_RXDATA;
    wire hit_st    = paddr == OFS_STATUS;
    wire hit_ev    = paddr == OFS_EVT;
    wire hit_evc   = paddr == OFS_EVT_CLR;
    wire hit_eve   = paddr == OFS_EVT_EN;
    wire mapped    = hit_ctrl | hit_pg | hit_ag | hit_rx | hit_st | hit_ev | hit_evc | hit_eve;
    wire wr_en     = acc_done & pwrite & mapped;
    wire st_read   = acc_done & ~pwrite & hit_st;

    wire [31:0] ctrl_word = 32'({cp_mode, irq_mode});
    wire [31:0] st_word   = 32'({early_steer, dsteer, rx_valid});
    wire [31:0] rd_word   =
        hit_ctrl ? ctrl_word :
        hit_pg   ? 32'(pguard) :
        hit_ag   ? 32'(aguard) :
        hit_rx   ? 32'(rx_code) :
        hit_st   ? st_word :
        hit_ev   ? 32'(evt) :
        hit_eve  ? 32'(evt_en) : 32'h0000_0000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_first;
            prdata  <= (acc_first & ~pwrite) ? rd_word : 32'h0000_0000;
            pslverr <= acc_first & ~mapped;
        end
    end

    // signal condition; call progress mode disables digit detection
    wire est_now = low_m.valid & high_m.valid & ~cp_mode;
    wire [3:0] code_now = code_of(low_m.idx, high_m.idx);

    // steering counter stands in for the rc node
    wire pg_reached = scnt >= pguard - GUARD_W'(1);
    wire ag_reached = scnt >= aguard - GUARD_W'(1);
    wire settle_end = scnt >= GUARD_W'(SETTLE_CYC - 1);
    wire reg_now    = (state == ST_QUAL) && est_now && pg_reached;
    wire flag_rise  = (state == ST_SETTLE) && settle_end;
    wire pause_end  = (state == ST_HELD) && !est_now && ag_reached;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:   next_state = est_now ? ST_QUAL : ST_IDLE;
            ST_QUAL: begin
                if (!est_now)
                    next_state = ST_IDLE;
                else if (pg_reached)
                    next_state = ST_SETTLE;
            end
            ST_SETTLE: next_state = settle_end ? ST_HELD : ST_SETTLE;
            ST_HELD:   next_state = pause_end ? ST_IDLE : ST_HELD;
            default:   next_state = ST_IDLE;
        endcase
    end

    // count up while qualifying, settling or held with tones absent, restart on each phase change
    wire [GUARD_W-1:0] next_scnt =
        (next_state != state)                 ? GUARD_W'(0) :
        (state == ST_IDLE)                    ? GUARD_W'(0) :
        (state == ST_HELD && est_now)         ? GUARD_W'(0) :
        scnt + GUARD_W'(1);

    wire next_guard = (next_state == ST_SETTLE || next_state == ST_HELD) && est_now;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_IDLE;
            scnt        <= '0;
            early_steer <= 1'b0;
            guard_drive <= 1'b0;
            dsteer      <= 1'b0;
            pend_code   <= CODE_D;
            rx_code     <= CODE_D;
        end else begin
            state       <= next_state;
            scnt        <= next_scnt;
            early_steer <= est_now;
            guard_drive <= next_guard;
            if (reg_now)
                pend_code <= code_now;
            if (flag_rise) begin
                dsteer  <= 1'b1;
                rx_code <= pend_code;
            end else if (pause_end) begin
                dsteer  <= 1'b0;
            end
        end
    end

    // status valid and pin interrupt: a new pair wins over a status read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            irq_pend <= 1'b0;
        end else begin
            rx_valid <= flag_rise | (rx_valid & ~st_read);
            irq_pend <= flag_rise | (irq_pend & ~st_read);
        end
    end

    // open drain: oe high pulls the line low
    wire next_pin_oe = cp_mode ? ~sync_b[2] : (irq_mode & irq_pend);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_or_tone_out_o  <= 1'b0;
            irq_or_tone_out_oe <= 1'b0;
        end else begin
            irq_or_tone_out_o  <= 1'b0;
            irq_or_tone_out_oe <= next_pin_oe;
        end
    end

    // control and guard registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mode <= 1'b0;
            cp_mode  <= 1'b0;
            pguard   <= GUARD_W'(PRESENT_GUARD_CYC);
            aguard   <= GUARD_W'(ABSENT_GUARD_CYC);
            evt_en   <= '0;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                irq_mode <= pwdata[CTRL_IRQ_BIT];
                cp_mode  <= pwdata[CTRL_CP_BIT];
            end
            if (hit_pg)
                pguard <= pwdata[GUARD_W-1:0];
            if (hit_ag)
                aguard <= pwdata[GUARD_W-1:0];
            if (hit_eve)
                evt_en <= pwdata[EV_W-1:0];
        end
    end

    // sticky events, write one to clear, set beats clear
    wire [EV_W-1:0] ev_set = EV_W'({pause_end, flag_rise});
    wire [EV_W-1:0] ev_clr = (wr_en & hit_evc) ? pwdata[EV_W-1:0] : '0;
    wire [EV_W-1:0] next_evt = ev_set | (evt & ~ev_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= '0;
            irq <= 1'b0;
        end else begin
            evt <= next_evt;
            irq <= |(next_evt & evt_en);
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_early_drop: assert property (!est_now |=> !early_steer)
        else $error("early steering stayed high after loss of tones");

    chk_code_capture: assert property (reg_now |=> pend_code == $past(code_now))
        else $error("latched code differs from decoded pair");

    chk_latch_only: assert property ($changed(rx_code) |-> $rose(dsteer))
        else $error("receive latch changed without flag rising");

    chk_settle_flag: assert property (reg_now |-> ##[1:8] $rose(dsteer))
        else $error("delayed steering did not follow registration");

    chk_short_reject: assert property
        ((state == ST_QUAL && !est_now) |=> (state == ST_IDLE && $stable(rx_code)))
        else $error("short pair was not rejected");

    chk_guard_follow: assert property (guard_drive |-> early_steer && state != ST_QUAL)
        else $error("guard drive high without early steering");

    chk_irq_pin: assert property
        ((irq_mode && !cp_mode && irq_pend) |=> irq_or_tone_out_oe)
        else $error("interrupt pin not pulled low");

    chk_status_clear: assert property ((st_read && !flag_rise) |=> !rx_valid && !irq_pend)
        else $error("status read did not clear valid and interrupt");

    chk_cp_no_digit: assert property (cp_mode |=> !early_steer)
        else $error("digit detected in call progress mode");

    chk_dropout_hold: assert property
        ((state == ST_HELD && !est_now && !ag_reached) |=> dsteer && $stable(rx_code))
        else $error("short dropout ended the registered pair");
endmodule : tone_pair_decode_steering

// >>> verif/tone_src.sv
// Purpose: line side model giving limited low and high group tones
// Assumes: half periods are given in pclk cycles
// Notes:   when stopped both lines toggle every cycle, like out-of-band noise,
//          so a stale level never passes for a tone
`timescale 1ns/1ns
module tone_src (
    // clock
    input  wire logic        pclk,
    // control
    input  wire logic        run,
    input  wire logic [15:0] low_half,
    input  wire logic [15:0] high_half,
    // limited tones
    output logic             low_tone,
    output logic             high_tone
);
    logic [15:0] lc;
    logic [15:0] hc;

    initial begin
        low_tone = 1'b0;
        high_tone = 1'b0;
        lc = 16'h0;
        hc = 16'h0;
    end

    always @(posedge pclk) begin
        if (!run) begin
            lc <= 16'h0;
            hc <= 16'h0;
            low_tone <= ~low_tone;
            high_tone <= ~high_tone;
        end else begin
            lc <= (lc + 16'h1 >= low_half) ? 16'h0 : lc + 16'h1;
            hc <= (hc + 16'h1 >= high_half) ? 16'h0 : hc + 16'h1;
            if (lc + 16'h1 >= low_half) low_tone <= ~low_tone;
            if (hc + 16'h1 >= high_half) high_tone <= ~high_tone;
        end
    end
endmodule : tone_src

// >>> verif/tone_pair_decode_steering_tb.sv
// Purpose: self-checking bench for the tone pair decoder
// Assumes: guards shortened to 50 cycles; tones are real frequencies
// Notes:   a tone burst costs tens of thousands of cycles, so few are used
`timescale 1ns/1ns
module tone_pair_decode_steering_tb;
    import tone_pkg::*;
    localparam int          GUARD     = 50;
    localparam logic [15:0] LOW_HALF  = 16'(CLK_HZ / LOW_F3 / 2);
    localparam logic [15:0] HIGH_HALF = 16'(CLK_HZ / HIGH_F2 / 2);
    logic        pclk, presetn, psel, penable, pwrite;
    logic        cp_tone, run, low_tone, high_tone;
    logic        early_steer, guard_drive, pin_o, pin_oe, irq, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          failures;
    int          checks_done;

    tone_pair_decode_steering #(.PRESENT_GUARD_CYC(GUARD), .ABSENT_GUARD_CYC(GUARD)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_tone(low_tone), .high_tone(high_tone), .cp_tone(cp_tone),
        .early_steer(early_steer), .guard_drive(guard_drive),
        .irq_or_tone_out_o(pin_o), .irq_or_tone_out_oe(pin_oe), .irq(irq));

    tone_src line (.pclk(pclk), .run(run), .low_half(LOW_HALF), .high_half(HIGH_HALF),
        .low_tone(low_tone), .high_tone(high_tone));

    initial begin
        pclk = 1'b0;
        forever #(CLK_NS / 2) pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    task automatic check_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit

    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    // holds the request until pready is sampled high; data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check_bit("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check_bit("write pslverr", 1'b0, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check_word(nm, exp, r);
        check_bit("read pslverr", 1'b0, e);
    endtask : rd_chk

    // bounded wait on one of the design's level outputs
    task automatic wait_on(input string nm, input int sel, input logic lvl, input int lim);
        int   n;
        logic s;
        n = 0;
        do begin
            // sampled mid-cycle so the edge that launches a level is not raced
            @(negedge pclk);
            n++;
            s = (sel == 0) ? early_steer : (sel == 1) ? guard_drive : irq;
        end while (s !== lvl && n < lim);
        check_bit(nm, lvl, s);
    endtask : wait_on

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        check_bit("early_steer", 1'b0, early_steer);
        check_bit("guard_drive", 1'b0, guard_drive);
        check_bit("pin oe", 1'b0, pin_oe);
        check_bit("irq", 1'b0, irq);
        rd_chk("status", OFS_STATUS, 32'h0);
        rd_chk("rxdata", OFS_RXDATA, 32'h0);
        rd_chk("pguard", OFS_PGUARD, 32'(GUARD));
        apb(1'b0, 8'h20, 32'h0, r, e);
        check_bit("unmapped pslverr", 1'b1, e);
        check_word("unmapped data", 32'h0, r);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cp();
        wr(OFS_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            cp_tone <= i[0];
            repeat (5) @(posedge pclk);
            check_bit("cp pin oe", ~cp_tone, pin_oe);
            check_bit("cp pin o", 1'b0, pin_o);
        end
        wr(OFS_CTRL, 32'h1);
        wr(OFS_EVT_EN, 32'h1);
        wr(OFS_AGUARD, 32'h30000);
        $display("test call progress done");
    endtask : t_cp

    task automatic t_short();
        run <= 1'b1;
        wait_on("early rise", 0, 1'b1, 100000);
        repeat (20) @(posedge pclk);
        run <= 1'b0;
        wait_on("early drop", 0, 1'b0, 10);
        repeat (100) @(posedge pclk);
        check_bit("short guard", 1'b0, guard_drive);
        check_bit("short irq", 1'b0, irq);
        rd_chk("short status", OFS_STATUS, 32'h0);
        rd_chk("short evt", OFS_EVT, 32'h0);
        $display("test short burst done");
    endtask : t_short

    task automatic t_reg();
        run <= 1'b1;
        wait_on("early rise", 0, 1'b1, 100000);
        repeat (40) @(posedge pclk);
        check_bit("guard early", 1'b0, guard_drive);
        wait_on("guard rise", 1, 1'b1, 30);
        wait_on("irq rise", 2, 1'b1, 20);
        // pin follows the pending flag one register later than irq
        @(negedge pclk);
        check_bit("pin low", 1'b1, pin_oe);
        rd_chk("rxdata", OFS_RXDATA, {28'h0, CODE_HASH});
        rd_chk("status", OFS_STATUS, 32'h7);
        rd_chk("status reread", OFS_STATUS, 32'h6);
        check_bit("pin released", 1'b0, pin_oe);
        wr(OFS_EVT_EN, 32'h0);
        repeat (2) @(posedge pclk);
        check_bit("irq masked", 1'b0, irq);
        wr(OFS_EVT_EN, 32'h1);
        repeat (2) @(posedge pclk);
        check_bit("irq unmasked", 1'b1, irq);
        wr(OFS_EVT_CLR, 32'h1);
        repeat (2) @(posedge pclk);
        check_bit("irq cleared", 1'b0, irq);
        $display("test registration done");
    endtask : t_reg

    task automatic t_drop();
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        run <= 1'b1;
        wait_on("guard drop", 1, 1'b0, 20);
        wait_on("early back", 0, 1'b1, 100000);
        repeat (100) @(posedge pclk);
        rd_chk("drop status", OFS_STATUS, 32'h6);
        rd_chk("drop rxdata", OFS_RXDATA, {28'h0, CODE_HASH});
        rd_chk("drop evt", OFS_EVT, 32'h0);
        wr(OFS_AGUARD, 32'(GUARD));
        run <= 1'b0;
        wait_on("early end", 0, 1'b0, 20);
        repeat (70) @(posedge pclk);
        rd_chk("pause status", OFS_STATUS, 32'h0);
        rd_chk("pause evt", OFS_EVT, 32'h2);
        check_bit("pause irq", 1'b0, irq);
        $display("test dropout and pause done");
    endtask : t_drop

    initial begin
        failures = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        cp_tone = 1'b0;
        run = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cp();
        t_short();
        t_reg();
        t_drop();
        summarize();
    end

    // about fifteen low-group periods, near twice the three bursts of two or three periods each
    initial begin
        #(CLK_NS * 400000);
        failures++;
        $display("mismatch watchdog expected done seen hang");
        summarize();
    end
endmodule : tone_pair_decode_steering_tb
